// >>> rtl/sac_pkg.sv
// Package for the converter control block: offsets, fields, resets.
// Assumes a 32-bit AXI4-Lite register bus and one 100 MHz clock.
package sac_pkg;
    // Register byte offsets
    localparam logic [5:0] SAC_OFF_CHAN = 6'h00;
    localparam logic [5:0] SAC_OFF_CFG = 6'h04;
    localparam logic [5:0] SAC_OFF_CMP = 6'h08;
    localparam logic [5:0] SAC_OFF_RESH = 6'h0c;
    localparam logic [5:0] SAC_OFF_RESL = 6'h10;
    localparam logic [5:0] SAC_OFF_STAT = 6'h14;
    localparam logic [5:0] SAC_OFF_ICLR = 6'h18;
    localparam logic [5:0] SAC_OFF_IEN = 6'h1c;
    localparam logic [5:0] SAC_OFF_PINS = 6'h20;
    // Channel field values
    localparam logic [4:0] SAC_CHAN_OFF = 5'h1f;
    localparam logic [4:0] SAC_CHAN_NUM = 5'h1c;
    // Config field positions and reset value
    localparam int SAC_CFG_MODE10 = 0;
    localparam int SAC_CFG_SEL = 1;
    localparam int SAC_CFG_DIV = 3;
    localparam int SAC_CFG_CMPEN = 5;
    localparam int SAC_CFG_CMPGT = 6;
    localparam logic [6:0] SAC_CFG_RST = 7'h00;
    // Status bit positions
    localparam int SAC_ST_DONE = 0;
    localparam int SAC_ST_HIT = 1;
    // Raw result widths
    localparam logic [3:0] SAC_MSB10 = 4'ha;
    localparam logic [3:0] SAC_MSB8 = 4'h8;
    localparam logic [3:0] SAC_LEN10 = 4'hb;
    localparam logic [3:0] SAC_LEN8 = 4'h9;
    // Bus answers
    localparam logic [1:0] SAC_RESP_OK = 2'h0;
    localparam logic [1:0] SAC_RESP_ERR = 2'h2;
    // Converter clock sources
    typedef enum logic [1:0] {
        SAC_CK_BUS = 2'b00,
        SAC_CK_BUS2 = 2'b01,
        SAC_CK_ALT = 2'b10,
        SAC_CK_ASYNC = 2'b11
    } sac_clk_sel_t;
    // Approximation engine states
    typedef enum logic {
        SAC_IDLE = 1'b0,
        SAC_CONV = 1'b1
    } sac_state_t;
endpackage

// >>> rtl/sac_conv_if.sv
// Link between the control core and the approximation engine.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface sac_conv_if;
    logic start; // Begin a conversion
    logic abort; // Drop a running conversion
    logic mode10; // 1 = 10-bit mode
    logic tick; // Converter clock enable
    logic compIn; // Comparator: input above trial
    logic busy; // Conversion running
    logic done; // One-cycle completion pulse
    logic [10:0] raw; // Trial word, final raw result
    modport ctl (output start, abort, mode10, tick, compIn,
        input busy, done, raw);
    modport eng (input start, abort, mode10, tick, compIn,
        output busy, done, raw);
endinterface

// >>> rtl/sac_clk_div.sv
// Converter clock source select and divider, as a tick enable.
// Assumes alternate and async sources arrive as one-cycle ticks.
`timescale 1ns/100ps
module sac_clk_div
    import sac_pkg::*;
#(
    parameter int DIV_W = 2
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [1:0] clkSel,
    input wire logic [DIV_W-1:0] divSel,
    input wire logic altTick,
    input wire logic asyncTick,
    input wire logic run,
    output logic tick
);
    logic half_reg; // Bus clock halved
    logic srcEn; // Selected source edge
    logic [7:0] cnt_reg; // Divider count
    logic [7:0] divLast; // Terminal count

    // Halved bus clock runs freely
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) half_reg <= 1'b0;
        else half_reg <= ~half_reg;
    end

    // Source mux
    always_comb begin
        divLast = 8'((9'h1 << divSel) - 9'h1);
        case (sac_clk_sel_t'(clkSel))
            SAC_CK_BUS: srcEn = 1'b1;
            SAC_CK_BUS2: srcEn = half_reg;
            SAC_CK_ALT: srcEn = altTick;
            default: srcEn = asyncTick;
        endcase
    end

    // Divider and tick pulse
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= 8'h00;
            tick <= 1'b0;
        end else if (!run) begin
            cnt_reg <= 8'h00;
            tick <= 1'b0;
        end else if (srcEn && cnt_reg >= divLast) begin
            cnt_reg <= 8'h00;
            tick <= 1'b1;
        end else begin
            cnt_reg <= srcEn ? cnt_reg + 8'h01 : cnt_reg;
            tick <= 1'b0;
        end
    end

    property p_bus_full;
        @(posedge clk) disable iff (!rst_n)
        (run && clkSel == SAC_CK_BUS && divSel == '0) [*2] |-> tick;
    endproperty
    a_bus_full: assert property (p_bus_full)
        else $error("bus clock undivided gives no tick");
endmodule

// >>> rtl/sac_sar_engine.sv
// Successive approximation sequencer, one bit per converter tick.
// Assumes the comparator answers within the tick it is sampled on.
`timescale 1ns/100ps
module sac_sar_engine
    import sac_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    sac_conv_if.eng cv
);
    sac_state_t state_reg; // Engine state
    logic [3:0] bitIdx_reg; // Bit under trial
    logic [10:0] trial_reg; // Trial word
    logic done_reg; // Completion pulse
    logic mode_reg; // Mode latched at start
    logic [3:0] tickCnt_reg; // Ticks seen, for checking

    assign cv.busy = (state_reg == SAC_CONV);
    assign cv.done = done_reg;
    assign cv.raw = trial_reg;

    // Bit walk from MSB down
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= SAC_IDLE;
            bitIdx_reg <= 4'h0;
            trial_reg <= 11'h000;
            done_reg <= 1'b0;
            mode_reg <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            case (state_reg)
                SAC_IDLE: begin
                    if (cv.start) begin
                        state_reg <= SAC_CONV;
                        mode_reg <= cv.mode10;
                        bitIdx_reg <= cv.mode10 ? SAC_MSB10 : SAC_MSB8;
                        trial_reg <= cv.mode10 ? 11'h400 : 11'h100;
                    end
                end
                default: begin
                    if (cv.abort) begin
                        state_reg <= SAC_IDLE;
                    end else if (cv.start) begin
                        mode_reg <= cv.mode10;
                        bitIdx_reg <= cv.mode10 ? SAC_MSB10 : SAC_MSB8;
                        trial_reg <= cv.mode10 ? 11'h400 : 11'h100;
                    end else if (cv.tick) begin
                        if (!cv.compIn) trial_reg[bitIdx_reg] <= 1'b0;
                        if (bitIdx_reg == 4'h0) begin
                            state_reg <= SAC_IDLE;
                            done_reg <= 1'b1;
                        end else begin
                            trial_reg[bitIdx_reg - 4'h1] <= 1'b1;
                            bitIdx_reg <= bitIdx_reg - 4'h1;
                        end
                    end
                end
            endcase
        end
    end

    // Tick counter for the width check
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) tickCnt_reg <= 4'h0;
        else if (cv.start) tickCnt_reg <= 4'h0;
        else if (cv.busy && cv.tick) tickCnt_reg <= tickCnt_reg + 4'h1;
    end

    property p_raw_width;
        @(posedge clk) disable iff (!rst_n)
        done_reg |-> tickCnt_reg == (mode_reg ? SAC_LEN10 : SAC_LEN8);
    endproperty
    a_raw_width: assert property (p_raw_width)
        else $error("raw result length wrong for mode");
endmodule

// >>> rtl/sac_adc_ctrl.sv
// Overview of operation
// - Disabled in reset or channel all ones
// - Idle at lowest power between conversions
// - Raw result 11 bits, 9 in 8-bit
// - 10-bit: round, store high and low
// - 8-bit: round, store low only
// - Then set done flag, interrupt if enabled
// - Compare enable checks every result
// - Four clock sources, then a divider
// - Bus clock source after reset
// - Bus clock halved source, up to sixteen
// - Alternate clock source to the divider
// - Async source ticks the divider only while a conversion runs
// - Pin bits disable channel 17, 16 I/O
// - Up to twenty-eight analog channels
//
// Top of the converter control: AXI4-Lite registers, result store.
// Assumes the analog front end follows chanSel and dacCode.
//
// The register offsets and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/100ps
module sac_adc_ctrl
    import sac_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [5:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [5:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic altClkTick,
    input wire logic asyncClkTick,
    input wire logic compIn,
    output logic [10:0] dacCode,
    output logic [4:0] chanSel,
    output logic convEnable,
    output logic lowPower,
    output logic [1:0] pinIoDisable,
    output logic irq
);
    sac_conv_if cv(); // Link to the engine

    logic [5:0] awAddr_reg; // Held write address
    logic [31:0] wData_reg; // Held write data
    logic [3:0] wStrb_reg; // Held byte strobes
    logic doWr; // Write performed now
    logic [4:0] chan_reg; // Channel select field
    logic [6:0] cfg_reg; // Mode, clock, compare
    logic [9:0] cmp_reg; // Compare value
    logic [1:0] resHigh_reg; // Result high
    logic [7:0] resLow_reg; // Result low
    logic [1:0] stat_reg; // Sticky events
    logic [1:0] ien_reg; // Event enables
    logic [7:0] pins_reg; // Pin control register
    logic startReq; // Start pulse to engine
    logic offReq; // Channel turned off
    logic convTick; // Divided converter clock
    logic [9:0] round10; // Result rounded to 10 bits
    logic [7:0] round8; // Result rounded to 8 bits
    logic [9:0] cmpVal; // Rounded value for compare
    logic cmpHit; // Compare condition true
    logic [31:0] rdMux; // Read data mux
    logic rdErr; // Unmapped read
    logic wrErr; // Unmapped write

    // Clock select and divider
    sac_clk_div #(
        .DIV_W(2)
    ) u_div (
        .clk(clk),
        .rst_n(rst_n),
        .clkSel(cfg_reg[SAC_CFG_SEL +: 2]),
        .divSel(cfg_reg[SAC_CFG_DIV +: 2]),
        .altTick(altClkTick),
        .asyncTick(asyncClkTick),
        .run(cv.busy),
        .tick(convTick)
    );

    // Approximation engine
    sac_sar_engine u_eng (
        .clk(clk),
        .rst_n(rst_n),
        .cv(cv)
    );

    assign cv.start = startReq;
    assign cv.abort = offReq;
    assign cv.mode10 = cfg_reg[SAC_CFG_MODE10];
    assign cv.tick = convTick;
    assign cv.compIn = compIn;
    assign dacCode = cv.raw;
    assign chanSel = chan_reg;
    assign pinIoDisable = pins_reg[1:0];

    // Write address channel
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            awready <= 1'b1;
            awAddr_reg <= 6'h00;
        end else if (awvalid && awready) begin
            awready <= 1'b0;
            awAddr_reg <= awaddr;
        end else if (bvalid && bready) begin
            awready <= 1'b1;
        end
    end

    // Write data channel
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wready <= 1'b1;
            wData_reg <= 32'h0000_0000;
            wStrb_reg <= 4'h0;
        end else if (wvalid && wready) begin
            wready <= 1'b0;
            wData_reg <= wdata;
            wStrb_reg <= wstrb;
        end else if (bvalid && bready) begin
            wready <= 1'b1;
        end
    end

    // Both halves held and no answer pending
    assign doWr = !awready && !wready && !bvalid;

    // Unmapped write decode
    always_comb begin
        if (awAddr_reg == SAC_OFF_CHAN) wrErr = 1'b0;
        else if (awAddr_reg == SAC_OFF_CFG) wrErr = 1'b0;
        else if (awAddr_reg == SAC_OFF_CMP) wrErr = 1'b0;
        else if (awAddr_reg == SAC_OFF_ICLR) wrErr = 1'b0;
        else if (awAddr_reg == SAC_OFF_IEN) wrErr = 1'b0;
        else if (awAddr_reg == SAC_OFF_PINS) wrErr = 1'b0;
        else if (awAddr_reg == SAC_OFF_RESH) wrErr = 1'b0;
        else if (awAddr_reg == SAC_OFF_RESL) wrErr = 1'b0;
        else if (awAddr_reg == SAC_OFF_STAT) wrErr = 1'b0;
        else wrErr = 1'b1;
    end

    // Write response
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bvalid <= 1'b0;
            bresp <= SAC_RESP_OK;
        end else if (doWr) begin
            bvalid <= 1'b1;
            bresp <= wrErr ? SAC_RESP_ERR : SAC_RESP_OK;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // Conversion start and channel off requests
    always_comb begin
        startReq = 1'b0;
        offReq = 1'b0;
        if (doWr && awAddr_reg == SAC_OFF_CHAN && wStrb_reg[0]) begin
            if (wData_reg[4:0] == SAC_CHAN_OFF) offReq = 1'b1;
            else if (wData_reg[4:0] < SAC_CHAN_NUM) startReq = 1'b1;
        end
    end

    // Channel select, resets to off
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) chan_reg <= SAC_CHAN_OFF;
        else if (doWr && awAddr_reg == SAC_OFF_CHAN && wStrb_reg[0])
            chan_reg <= wData_reg[4:0];
    end

    // Converter enable follows channel field
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) convEnable <= 1'b0;
        else convEnable <= (chan_reg != SAC_CHAN_OFF);
    end

    // Low power whenever no conversion runs
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) lowPower <= 1'b1;
        else lowPower <= !cv.busy && !startReq;
    end

    // Configuration, bus clock source after reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) cfg_reg <= SAC_CFG_RST;
        else if (doWr && awAddr_reg == SAC_OFF_CFG && wStrb_reg[0])
            cfg_reg <= wData_reg[6:0];
    end

    // Compare value, two byte lanes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmp_reg <= 10'h000;
        end else if (doWr && awAddr_reg == SAC_OFF_CMP) begin
            if (wStrb_reg[0]) cmp_reg[7:0] <= wData_reg[7:0];
            if (wStrb_reg[1]) cmp_reg[9:8] <= wData_reg[9:8];
        end
    end

    // Pin control register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) pins_reg <= 8'h00;
        else if (doWr && awAddr_reg == SAC_OFF_PINS && wStrb_reg[0])
            pins_reg <= wData_reg[7:0];
    end

    // Rounding with saturation at full scale
    always_comb begin
        round10 = cv.raw[10:1];
        if (cv.raw[0] && cv.raw[10:1] != 10'h3ff)
            round10 = cv.raw[10:1] + 10'h001;
        round8 = cv.raw[8:1];
        if (cv.raw[0] && cv.raw[8:1] != 8'hff)
            round8 = cv.raw[8:1] + 8'h01;
        cmpVal = cfg_reg[SAC_CFG_MODE10] ? round10 : {2'h0, round8};
    end

    // Compare: greater-or-equal or less-than
    assign cmpHit = cfg_reg[SAC_CFG_CMPGT] ? (cmpVal >= cmp_reg)
        : (cmpVal < cmp_reg);

    // Result store on completion
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            resHigh_reg <= 2'h0;
            resLow_reg <= 8'h00;
        end else if (cv.done) begin
            if (cfg_reg[SAC_CFG_MODE10]) begin
                resHigh_reg <= round10[9:8];
                resLow_reg <= round10[7:0];
            end else begin
                resLow_reg <= round8;
            end
        end
    end

    // Sticky events, set wins over clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stat_reg <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (doWr && awAddr_reg == SAC_OFF_ICLR && wStrb_reg[0]
                    && wData_reg[i])
                    stat_reg[i] <= 1'b0;
            end
            if (cv.done) stat_reg[SAC_ST_DONE] <= 1'b1;
            if (cv.done && cfg_reg[SAC_CFG_CMPEN] && cmpHit)
                stat_reg[SAC_ST_HIT] <= 1'b1;
        end
    end

    // Interrupt enables
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) ien_reg <= 2'h0;
        else if (doWr && awAddr_reg == SAC_OFF_IEN && wStrb_reg[0])
            ien_reg <= wData_reg[1:0];
    end

    // Level interrupt
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) irq <= 1'b0;
        else irq <= |(stat_reg & ien_reg);
    end

    // Read decode
    always_comb begin
        rdMux = 32'h0000_0000;
        rdErr = 1'b0;
        if (araddr == SAC_OFF_CHAN) rdMux[4:0] = chan_reg;
        else if (araddr == SAC_OFF_CFG) rdMux[6:0] = cfg_reg;
        else if (araddr == SAC_OFF_CMP) rdMux[9:0] = cmp_reg;
        else if (araddr == SAC_OFF_RESH) rdMux[1:0] = resHigh_reg;
        else if (araddr == SAC_OFF_RESL) rdMux[7:0] = resLow_reg;
        else if (araddr == SAC_OFF_STAT) rdMux[2:0] = {cv.busy, stat_reg};
        else if (araddr == SAC_OFF_ICLR) rdMux = 32'h0000_0000;
        else if (araddr == SAC_OFF_IEN) rdMux[1:0] = ien_reg;
        else if (araddr == SAC_OFF_PINS) rdMux[7:0] = pins_reg;
        else rdErr = 1'b1;
    end

    // Read channel, one read at a time
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= SAC_RESP_OK;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= rdMux;
            rresp <= rdErr ? SAC_RESP_ERR : SAC_RESP_OK;
        end else if (rvalid && rready) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_finish;
        cv.done ##1 stat_reg[SAC_ST_DONE];
    endsequence

    property p_off;
        chan_reg == SAC_CHAN_OFF && !startReq |=> !convEnable && !cv.busy;
    endproperty
    a_off: assert property (p_off)
        else $error("converter enabled with channel off");

    property p_idle;
        cv.done && !startReq ##1 !startReq |-> lowPower ##1 lowPower;
    endproperty
    a_idle: assert property (p_idle)
        else $error("not in low power after completion");

    property p_store10;
        cv.done && cfg_reg[SAC_CFG_MODE10]
            |=> {resHigh_reg, resLow_reg} == $past(round10);
    endproperty
    a_store10: assert property (p_store10)
        else $error("10-bit result not stored");

    property p_store8;
        cv.done && !cfg_reg[SAC_CFG_MODE10] |=> resLow_reg == $past(round8)
            && resHigh_reg == $past(resHigh_reg);
    endproperty
    a_store8: assert property (p_store8)
        else $error("8-bit result stored wrongly");

    property p_irq;
        cv.done && ien_reg[SAC_ST_DONE] && !doWr |-> s_finish ##1 irq;
    endproperty
    a_irq: assert property (p_irq)
        else $error("done flag or interrupt missing");

    property p_cmp;
        cv.done && cfg_reg[SAC_CFG_CMPEN] && cmpHit |=> stat_reg[SAC_ST_HIT];
    endproperty
    a_cmp: assert property (p_cmp)
        else $error("compare hit not flagged");

    property p_start;
        startReq |=> cv.busy && !lowPower;
    endproperty
    a_start: assert property (p_start)
        else $error("channel write did not start conversion");

    property p_pins;
        doWr && awAddr_reg == SAC_OFF_PINS && wStrb_reg[0]
            |=> pinIoDisable == $past(wData_reg[1:0]);
    endproperty
    a_pins: assert property (p_pins)
        else $error("pin disable outputs disagree with register");
endmodule

// >>> testbench/sac_afe_model.sv
// Analog front end model: channel levels, comparator, slow clock ticks.
// Assumes the control presents its trial word on dacCode.
`timescale 1ns/100ps
module sac_afe_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [10:0] dacCode,
    input wire logic [4:0] chanSel,
    input wire logic convEnable,
    output logic compIn,
    output logic altClkTick,
    output logic asyncClkTick
);
    logic [3:0] cntReg; // Free-running divider, period 15
    logic [10:0] level; // Voltage of the chosen channel
    // Step the divider
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cntReg <= 4'h0;
        end else begin
            cntReg <= (cntReg == 4'he) ? 4'h0 : cntReg + 4'h1;
        end
    end
    // Alternate every third cycle, async every fifth
    assign altClkTick = (cntReg % 4'h3) == 4'h0;
    assign asyncClkTick = (cntReg % 4'h5) == 4'h0;
    // Top channel at full scale, others low odd levels
    assign level = (chanSel == 5'h1b) ? 11'h7ff : {3'h0, chanSel, 3'h3};
    // Toggle while disabled, never a stale answer
    assign compIn = convEnable ? (level >= dacCode) : cntReg[0];
endmodule

// >>> testbench/tb.sv
// Self-checking bench for the converter control over AXI4-Lite.
// Assumes the front end model supplies compIn and the slow ticks.
`timescale 1ns/100ps
module tb
    import sac_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [5:0] awaddr = 6'h00;
    logic [5:0] araddr = 6'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hf;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, compIn, altT, asyncT;
    logic convEnable, lowPower, irq;
    logic [1:0] bresp, rresp, pinIoDisable;
    logic [31:0] rdata, rd;
    logic [10:0] dacCode;
    logic [4:0] chanSel;
    logic [1:0] rs;
    int n_fail = 0;
    int n_compared = 0;
    // Clock, 10 ns period
    always #5 clk = ~clk;
    sac_adc_ctrl i_dut (.clk(clk), .rst_n(rst_n), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .altClkTick(altT), .asyncClkTick(asyncT), .compIn(compIn), .dacCode(dacCode),
        .chanSel(chanSel), .convEnable(convEnable), .lowPower(lowPower),
        .pinIoDisable(pinIoDisable), .irq(irq));
    sac_afe_model i_afe (.clk(clk), .rst_n(rst_n), .dacCode(dacCode), .chanSel(chanSel),
        .convEnable(convEnable), .compIn(compIn), .altClkTick(altT), .asyncClkTick(asyncT));
    // Value compare
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Bus write, response code left in rs
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        rs = bresp;
        bready <= 1'b0;
    endtask
    // Bus read into rd and rs
    task automatic rdr(input logic [5:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask
    // Level the model gives a channel
    function automatic logic [10:0] lvl(input logic [4:0] ch);
        return (ch == 5'd27) ? 11'h7ff : {3'h0, ch, 3'h3};
    endfunction
    // Round half up, saturate at full scale
    function automatic logic [31:0] rnd(input logic [10:0] raw, input logic m10);
        logic [11:0] s;
        s = m10 ? (raw >> 1) + raw[0] : (raw[8:0] >> 1) + raw[0];
        if (m10) return (s > 12'h3ff) ? 32'h3ff : {20'h0, s};
        return (s > 12'h0ff) ? 32'hff : {20'h0, s};
    endfunction
    // Clear status, start a channel, poll for done
    task automatic conv(input logic [4:0] ch);
        int n;
        n = 0;
        wr(SAC_OFF_ICLR, 32'h3);
        wr(SAC_OFF_CHAN, {27'h0, ch});
        chk("lowPower busy", 32'h0, {31'h0, lowPower});
        do begin
            rdr(SAC_OFF_STAT);
            n++;
        end while (rd[SAC_ST_DONE] !== 1'b1 && n < 300);
        chk("done", 32'h1, {31'h0, rd[SAC_ST_DONE]});
        chk("lowPower idle", 32'h1, {31'h0, lowPower});
        chk("convEnable", 32'h1, {31'h0, convEnable});
    endtask
    // Result registers against the rounded level
    task automatic res(input logic [4:0] ch, input logic m10, input logic [31:0] eh);
        chk("raw", {21'h0, lvl(ch) & (m10 ? 11'h7ff : 11'h1ff)}, {21'h0, dacCode});
        rdr(SAC_OFF_RESL);
        chk("resl", rnd(lvl(ch), m10) & 32'hff, rd);
        rdr(SAC_OFF_RESH);
        chk("resh", eh, rd);
    endtask
    // Verdict and end of run
    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Watchdog
    initial begin
        #400000;
        n_fail++;
        stop_test;
    end
    // Test sequence
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        chk("chanSel rst", 32'h1f, {27'h0, chanSel});
        chk("convEnable rst", 32'h0, {31'h0, convEnable});
        rdr(SAC_OFF_CFG);
        chk("cfg rst", 32'h0, rd);
        rdr(6'h24);
        chk("unmapped", {30'h0, SAC_RESP_ERR}, {30'h0, rs});
        wr(6'h24, 32'h0);
        chk("bresp unmapped", {30'h0, SAC_RESP_ERR}, {30'h0, rs});
        $display("test reset done");
        // Restart mid conversion on the slowest bus division
        wr(SAC_OFF_IEN, 32'h1);
        chk("bresp ok", {30'h0, SAC_RESP_OK}, {30'h0, rs});
        wr(SAC_OFF_CFG, 32'h1b);
        wr(SAC_OFF_CHAN, 32'h1b);
        conv(5'd5);
        res(5'd5, 1'b1, rnd(lvl(5'd5), 1'b1) >> 8);
        chk("irq set", 32'h1, {31'h0, irq});
        wr(SAC_OFF_ICLR, 32'h1);
        @(posedge clk);
        chk("irq clr", 32'h0, {31'h0, irq});
        // Saturating 10-bit result
        wr(SAC_OFF_CFG, 32'h1);
        conv(5'd27);
        res(5'd27, 1'b1, 32'h3);
        $display("test 10-bit done");
        // 8-bit on every source, interrupt masked
        wr(SAC_OFF_IEN, 32'h0);
        for (int k = 0; k < 4; k++) begin
            wr(SAC_OFF_CFG, (k << 1) | (((k == 1) ? 3 : 1) << 3));
            conv(5'd9 + k[4:0]);
            res(5'd9 + k[4:0], 1'b0, 32'h3);
            chk("irq masked", 32'h0, {31'h0, irq});
        end
        $display("test 8-bit done");
        // Compare hit and miss at the boundary
        for (int k = 0; k < 4; k++) begin
            wr(SAC_OFF_CFG, (k < 2) ? 32'h61 : 32'h21);
            wr(SAC_OFF_CMP, rnd(lvl(5'd5), 1'b1) + k[0]);
            conv(5'd5);
            rdr(SAC_OFF_STAT);
            chk("hit", 32'(k == 0 || k == 3), {31'h0, rd[SAC_ST_HIT]});
        end
        $display("test compare done");
        // Pin control and disable
        wr(SAC_OFF_PINS, 32'h2);
        chk("pins", 32'h2, {30'h0, pinIoDisable});
        wr(SAC_OFF_CHAN, 32'h1f);
        @(posedge clk);
        chk("convEnable off", 32'h0, {31'h0, convEnable});
        $display("test pins and disable done");
        stop_test;
    end
endmodule
